// file: dv/sfm_peer.sv
`timescale 1ns/1ps
module sfm_peer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sdo,
  input wire logic pol,
  input wire logic go,
  input wire logic [10:0] len,
  output logic sdi,
  output logic ss_in
);
  logic [10:0] left;
  // Echo a clock late; bits stand a whole bit, so words return intact
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdi <= 1'b0;
      left <= 11'h000;
    end else begin
      sdi <= sdo;
      left <= go ? len : (left != 11'h000 ? left - 11'h001 : left);
    end
  end
  // Sync for one bit period, inactive level otherwise
  assign ss_in = (left != 11'h000) ? pol : !pol;
endmodule // sfm_peer

// file: dv/sfm_spi_top_props.sv
`timescale 1ns/1ps
module sfm_spi_top_props import sfm_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sck_out,
  input wire logic slave_select_pin_out,
  input wire logic slave_select_pin_oe_n,
  input wire logic select_pin_enable
);
  logic [15:0] ctl;
  logic [15:0] frm;
  logic [3:0] qt;
  logic [10:0] sc;
  logic [10:0] hc;
  int dv;
  // Setup writes, driven sync level, active bit clock
  wire wr = wb_ack_o && wb_we_i;
  wire cfg = wr && (wb_adr_i == SFM_OFS_CTRL || wb_adr_i == SFM_OFS_FRAME);
  wire calm = qt == 4'hF;
  wire act = !slave_select_pin_oe_n && slave_select_pin_out == frm[13];
  wire sact = sck_out != ctl[6];
  assign dv = (ctl[1:0] == 2'h2 ? 4 : ctl[1:0] == 2'h1 ? 16 : ctl[1:0] == 2'h0 ? 64 : 1)
    * (8 - ctl[4:2]);
  // Shadow copies; the bench always writes all lanes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 16'h0000;
      frm <= 16'h0000;
    end else if (wr && wb_adr_i == SFM_OFS_CTRL) begin
      ctl <= wb_dat_i[15:0] & SFM_CTRL_MASK;
    end else if (wr && wb_adr_i == SFM_OFS_FRAME) begin
      frm <= wb_dat_i[15:0] & SFM_FRAME_MASK;
    end
  end
  // Settling time hides the glitch a setup change may cause
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qt <= 4'h0;
      sc <= 11'h000;
      hc <= 11'h000;
    end else if (ce) begin
      // Frozen cycles are not part of any pulse length
      qt <= cfg ? 4'h0 : (calm ? qt : qt + 4'h1);
      sc <= act ? sc + 11'h001 : 11'h000;
      hc <= sact ? hc + 11'h001 : 11'h000;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i;
  endsequence
  sequence s_sync_end;
    $fell(act) ##0 calm;
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_cause: assert property (wb_ack_o |-> s_req)
    else $error("ack without request");
  a_frame_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SFM_OFS_FRAME
    |-> wb_dat_o == {16'h0000, frm}) else $error("frame readback wrong");
  a_pin_owner: assert property (calm |-> slave_select_pin_oe_n == !(frm[15] && !frm[14]))
    else $error("select pin drive wrong");
  a_sync_width: assert property (s_sync_end |-> sc == 2 * dv)
    else $error("sync pulse length wrong");
  a_half_width: assert property ($fell(sact) && calm |-> hc == dv)
    else $error("bit clock phase length wrong");
  a_sync_precede: assert property (act && !frm[1] && calm |-> !sact)
    else $error("clock active during early sync");
  a_sync_coincide: assert property ($rose(act) && frm[1] && calm |-> sact)
    else $error("sync not on first clock");
  a_pin_enable: assert property (calm |-> select_pin_enable == ctl[7])
    else $error("select enable copy wrong");
endmodule // sfm_spi_top_props
bind sfm_spi_top sfm_spi_top_props u_props (.clock, .rst_n, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_out, .slave_select_pin_out,
  .slave_select_pin_oe_n, .select_pin_enable);

// file: dv/spi_framed_mode_control_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module spi_framed_mode_control_test import sfm_pkg::*;;
  logic clock, rst_n, ce, cyc, stb, we, go, pol, ckp, sdi, ss_in;
  logic sck, sdo, ss_out, oe_n, ack;
  logic [7:0] adr, tx;
  logic [31:0] wdat, rdat, seed;
  logic [15:0] q, tw;
  logic [1:0] pri;
  logic [2:0] sec;
  int num_errors, check_count, n;
  sfm_spi_top dut (.clock, .rst_n, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sck_out(sck), .sdo_out(sdo), .sdi_in(sdi), .slave_select_pin_in(ss_in),
    .slave_select_pin_out(ss_out), .slave_select_pin_oe_n(oe_n), .select_pin_enable());
  sfm_peer peer (.clock, .rst_n, .sdo, .pol, .go, .len(11'h010), .sdi, .ss_in);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int div(logic [1:0] p, logic [2:0] s);
    return (p == 2'h2 ? 4 : p == 2'h1 ? 16 : p == 2'h0 ? 64 : 1) * (8 - s);
  endfunction
  // Classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 16'h0000, d};
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat[15:0];
    {cyc, stb} <= 2'b00;
  endtask
  // Length of the next stretch at level lv of sync or bit clock
  task automatic span(input bit w, input logic lv);
    n = 0;
    while ((w ? ss_out : sck) !== lv) @(posedge clock);
    while ((w ? ss_out : sck) === lv) begin
      n++;
      @(posedge clock);
    end
  endtask
  task automatic drain();
    do bus(1'b0, SFM_OFS_STATUS, 16'h0000); while (q[2] !== 1'b0 || q[1] !== 1'b1);
  endtask
  task automatic test_done();
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    test_done();
  end
  initial begin
    {rst_n, cyc, stb, we, go, pol, adr, wdat, num_errors, check_count} = '0;
    ce = 1'b1;
    seed = 32'h0000CE5C;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, SFM_OFS_FRAME, 16'h0000);
    `CHK("frame reset", 16'h0000, q)
    bus(1'b1, SFM_OFS_FRAME, 16'hFFFF);
    bus(1'b0, SFM_OFS_FRAME, 16'h0000);
    `CHK("frame mask", 16'hE003, q)
    bus(1'b0, 8'h20, 16'h0000);
    `CHK("unmapped", 16'h0000, q)
    // Prescale scan in byte mode; 1:1 pairs never used
    for (int i = 0; i < 3; i++) begin
      pri = 2'(2 - i);
      sec = 3'(rnd() % 7);
      ckp = 1'(rnd());
      tx = 8'(rnd());
      bus(1'b1, SFM_OFS_CTRL, 16'h8080 | {ckp, 1'b0, sec, pri});
      bus(1'b1, SFM_OFS_FRAME, 16'h0000);
      bus(1'b1, SFM_OFS_TXDATA, {8'h00, tx});
      span(1'b0, ~ckp);
      `CHK("half bit", div(pri, sec), n)
      drain();
      bus(1'b0, SFM_OFS_RXDATA, 16'h0000);
      `CHK("echo", tx, q[7:0])
    end
    // Word mode, data moving on the late clock edge
    bus(1'b1, SFM_OFS_CTRL, 16'h851A);
    tw = 16'(rnd());
    bus(1'b1, SFM_OFS_TXDATA, tw);
    drain();
    bus(1'b0, SFM_OFS_RXDATA, 16'h0000);
    `CHK("word echo", tw, q)
    // Driven sync, every polarity and edge choice, buffer enable bit clear
    bus(1'b1, SFM_OFS_CTRL, 16'h801A);
    for (int m = 0; m < 4; m++) begin
      pol <= m[0];
      bus(1'b1, SFM_OFS_FRAME, {2'b10, m[0], 11'h000, m[1], 1'b0});
      bus(1'b1, SFM_OFS_TXDATA, 16'(rnd()));
      `CHK("driving", 1'b0, oe_n)
      span(1'b1, pol);
      `CHK("sync bit", 16, n)
      drain();
    end
    // Received sync: nothing moves until the peer pulses
    pol <= 1'(rnd());
    tx = 8'(rnd());
    @(posedge clock);
    bus(1'b1, SFM_OFS_FRAME, {2'b11, pol, 13'h0000});
    bus(1'b1, SFM_OFS_TXDATA, {8'h00, tx});
    repeat (40) @(posedge clock);
    `CHK("released", 1'b1, oe_n)
    `CHK("waits sync", 1'b0, sck)
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    drain();
    bus(1'b0, SFM_OFS_RXDATA, 16'h0000);
    `CHK("framed echo", tx, q[7:0])
    // Buffered mode queues, plain mode takes one word
    bus(1'b1, SFM_OFS_FRAME, 16'h0001);
    for (int k = 0; k < 9; k++) begin
      bus(1'b1, SFM_OFS_TXDATA, 16'(rnd()));
      bus(1'b0, SFM_OFS_STATUS, 16'h0000);
      `CHK("room", k == 8, q[0])
    end
    drain();
    // Nine words and no reads leave a full, overrun receiver
    `CHK("overflow", 2'b11, q[4:3])
    bus(1'b1, SFM_OFS_STATUS, 16'h0010);
    bus(1'b0, SFM_OFS_STATUS, 16'h0000);
    `CHK("ovf clear", 2'b01, q[4:3])
    bus(1'b1, SFM_OFS_FRAME, 16'h0000);
    bus(1'b1, SFM_OFS_TXDATA, 16'h00A5);
    bus(1'b0, SFM_OFS_STATUS, 16'h0000);
    `CHK("single", 1'b1, q[0])
    // Clock enable low must hold the word mid-flight, five halves long
    ce <= 1'b0;
    @(posedge clock);
    tx[0] = sck;
    repeat (40) @(posedge clock);
    `CHK("frozen", tx[0], sck)
    ce <= 1'b1;
    drain();
    bus(1'b0, SFM_OFS_RXDATA, 16'h0000);
    `CHK("frozen echo", 8'hA5, q[7:0])
    test_done();
  end
endmodule // spi_framed_mode_control_test

// file: inc/sfm_pkg.sv
// How it works
// - Primary prescale codes divide by 4, 16, 64 or 1
// - Framed enable turns select pin into sync
// - Direction bit picks sync input or output
// - Polarity bit sets sync active level
// - Edge select: coincide or precede first bit
// - Buffer enable picks enhanced or standard mode
package sfm_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] SFM_OFS_CTRL = 8'h00;
  localparam logic [7:0] SFM_OFS_FRAME = 8'h04;
  localparam logic [7:0] SFM_OFS_TXDATA = 8'h08;
  localparam logic [7:0] SFM_OFS_RXDATA = 8'h0C;
  localparam logic [7:0] SFM_OFS_STATUS = 8'h10;
  localparam int unsigned SFM_REG_W = 16;
  localparam logic [15:0] SFM_CTRL_MASK = 16'h85DF;
  localparam logic [15:0] SFM_FRAME_MASK = 16'hE003;
  localparam logic [15:0] SFM_RESET_VALUE = 16'h0000;
  // Control register fields
  localparam int unsigned SFM_C_PRI_LO = 0;
  localparam int unsigned SFM_C_SEC_LO = 2;
  localparam int unsigned SFM_C_CKP = 6;
  localparam int unsigned SFM_C_SELECT_PIN_ENABLE = 7;
  localparam int unsigned SFM_C_CKE = 8;
  localparam int unsigned SFM_C_MODE16 = 10;
  localparam int unsigned SFM_C_ENABLE = 15;
  // Frame control register fields
  localparam int unsigned SFM_F_FRAMED = 15;
  localparam int unsigned SFM_F_DIR = 14;
  localparam int unsigned SFM_F_POL = 13;
  localparam int unsigned SFM_F_EDGE = 1;
  localparam int unsigned SFM_F_BUFEN = 0;
  // Status register fields
  localparam int unsigned SFM_S_TXFULL = 0;
  localparam int unsigned SFM_S_TXEMPTY = 1;
  localparam int unsigned SFM_S_BUSY = 2;
  localparam int unsigned SFM_S_RXFULL = 3;
  localparam int unsigned SFM_S_RXOVF = 4;
  // Prescale encodings and divide ratios
  localparam logic [1:0] SFM_PRI_4 = 2'h2;
  localparam logic [1:0] SFM_PRI_16 = 2'h1;
  localparam logic [1:0] SFM_PRI_64 = 2'h0;
  localparam logic [6:0] SFM_DIV_4 = 7'h04;
  localparam logic [6:0] SFM_DIV_16 = 7'h10;
  localparam logic [6:0] SFM_DIV_64 = 7'h40;
  localparam logic [6:0] SFM_DIV_1 = 7'h01;
  localparam logic [3:0] SFM_SEC_BASE = 4'h8;
  // Word lengths, as index of the last bit
  localparam logic [4:0] SFM_LAST_BIT16 = 5'h0F;
  localparam logic [4:0] SFM_LAST_BIT8 = 5'h07;
  localparam int unsigned SFM_FIFO_DEPTH = 8;
  typedef enum logic [3:0] {
    SFM_IDLE = 4'b0001,
    SFM_SYNC = 4'b0010,
    SFM_SHIFT = 4'b0100,
    SFM_DONE = 4'b1000
  } sfm_state_type;
endpackage

// file: inc/sfm_stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream between the port and its FIFO
interface sfm_stream_if #(parameter int unsigned WIDTH = 16) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// file: rtl/sfm_clkgen.sv
`timescale 1ns/1ps
module sfm_clkgen import sfm_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [1:0] primary,
  input wire logic [2:0] secondary,
  output logic tick
);
  logic [10:0] count;
  logic [6:0] pri_div;
  wire [3:0] sec_div = SFM_SEC_BASE - {1'b0, secondary};
  wire [10:0] limit = pri_div * sec_div - 11'h001;

  // Primary ratio decode, code 11 gives 1:1
  always_comb begin
    case (primary)
      SFM_PRI_4: pri_div = SFM_DIV_4;
      SFM_PRI_16: pri_div = SFM_DIV_16;
      SFM_PRI_64: pri_div = SFM_DIV_64;
      default: pri_div = SFM_DIV_1;
    endcase
  end

  assign tick = run && (count == limit);

  // Restart each frame so the first half bit is full length
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      count <= (!run || tick) ? 11'h000 : count + 11'h001;
    end
  end
endmodule // sfm_clkgen

// file: rtl/sfm_fifo.sv
`timescale 1ns/1ps
module sfm_fifo import sfm_pkg::*; #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  sfm_stream_if.sink push,
  sfm_stream_if.source pop
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire do_push = ce && push.valid && !full;
  wire do_pop = ce && pop.ready && !empty;

  // Handshakes straight from the pointers
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rptr[AW-1:0]];

  // Storage needs no reset; only pointers define contents
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wptr[AW-1:0]] <= push.data;
    end
  end

  // Extra pointer bit tells full from empty
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) wptr <= wptr + 1'b1;
      if (do_pop) rptr <= rptr + 1'b1;
    end
  end
endmodule // sfm_fifo

// file: rtl/sfm_spi_top.sv
`timescale 1ns/1ps
module sfm_spi_top import sfm_pkg::*; #(
  parameter int unsigned FIFO_DEPTH = SFM_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sck_out,
  output logic sdo_out,
  input wire logic sdi_in,
  input wire logic slave_select_pin_in,
  output logic slave_select_pin_out,
  output logic slave_select_pin_oe_n,
  output logic select_pin_enable
);
  // Register state
  logic [15:0] ctrl;
  logic [15:0] frame;
  logic [15:0] rx_data;
  logic rx_full;
  logic rx_overflow;
  logic ack;
  logic [31:0] rdata;

  // Serial engine state
  sfm_state_type state;
  sfm_state_type next_state;
  logic half;
  logic [4:0] bit_cnt;
  logic [15:0] tx_shift;
  logic [15:0] rx_shift;
  logic tick;

  sfm_stream_if #(.WIDTH(SFM_REG_W)) tx_push ();
  sfm_stream_if #(.WIDTH(SFM_REG_W)) tx_pop ();

  // Control field views
  wire enable = ctrl[SFM_C_ENABLE];
  wire mode16 = ctrl[SFM_C_MODE16];
  wire ckp = ctrl[SFM_C_CKP];
  wire [1:0] primary = ctrl[SFM_C_PRI_LO +: 2];
  wire [2:0] secondary = ctrl[SFM_C_SEC_LO +: 3];
  wire framed_mode_enable = frame[SFM_F_FRAMED];
  wire sync_pulse_direction = frame[SFM_F_DIR];
  wire sync_pulse_polarity = frame[SFM_F_POL];
  wire sync_pulse_edge_select = frame[SFM_F_EDGE];
  wire enhanced_buffer_enable = frame[SFM_F_BUFEN];
  // Clock edge select has no effect while framed
  wire cke_eff = ctrl[SFM_C_CKE] && !framed_mode_enable;
  // Set direction bit makes the device a frame slave
  wire sync_is_input = framed_mode_enable && sync_pulse_direction;
  wire sync_is_output = framed_mode_enable && !sync_pulse_direction;

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i;
  wire hit_ctrl = (wb_adr_i == SFM_OFS_CTRL);
  wire hit_frame = (wb_adr_i == SFM_OFS_FRAME);
  wire hit_tx = (wb_adr_i == SFM_OFS_TXDATA);
  wire hit_rx = (wb_adr_i == SFM_OFS_RXDATA);
  wire hit_status = (wb_adr_i == SFM_OFS_STATUS);
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_commit = req && ack && wb_we_i;
  wire rd_commit = req && ack && !wb_we_i;
  wire busy = (state != SFM_IDLE);
  wire tx_empty = !tx_pop.valid;

  // Standard mode holds only one word in flight
  wire tx_room = tx_push.ready &&
    (enhanced_buffer_enable || (tx_empty && !busy));
  // A data write waits for room, which stalls the bus master
  wire can_ack = !(wb_we_i && hit_tx) || tx_room;

  assign tx_push.valid = wr_commit && hit_tx;
  assign tx_push.data = wb_dat_i[15:0];

  // Read multiplexer; unmapped addresses read zero
  wire [15:0] status_word = {11'h000, rx_overflow, rx_full, busy, tx_empty, !tx_room};
  wire [15:0] rd_mux =
    hit_ctrl ? ctrl :
    hit_frame ? (frame & SFM_FRAME_MASK) :
    hit_rx ? rx_data :
    hit_status ? status_word : 16'h0000;

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign select_pin_enable = ctrl[SFM_C_SELECT_PIN_ENABLE];

  // Ack one cycle after the request; writes land on the ack edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      ack <= req && !ack && can_ack;
      if (req && !ack) rdata <= {16'h0000, rd_mux};
    end
  end

  // Control registers honour byte lanes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= SFM_RESET_VALUE;
      frame <= SFM_RESET_VALUE;
    end else if (ce && wr_commit) begin
      if (hit_ctrl) begin
        ctrl <= (ctrl & ~lane_mask) | (wb_dat_i[15:0] & lane_mask & SFM_CTRL_MASK);
      end
      if (hit_frame) begin
        frame <= (frame & ~lane_mask) | (wb_dat_i[15:0] & lane_mask & SFM_FRAME_MASK);
      end
    end
  end

  sfm_fifo #(
    .WIDTH(SFM_REG_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .push(tx_push),
    .pop(tx_pop)
  );

  sfm_clkgen u_clkgen (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .run(busy),
    .primary(primary),
    .secondary(secondary),
    .tick(tick)
  );

  // Start conditions; an input sync is matched against polarity
  wire sync_seen = (slave_select_pin_in == sync_pulse_polarity);
  wire start_ok = enable && tx_pop.valid && (!sync_is_input || sync_seen);
  wire [4:0] last_bit = mode16 ? SFM_LAST_BIT16 : SFM_LAST_BIT8;
  wire last_half = tick && half;
  assign tx_pop.ready = (state == SFM_IDLE) && start_ok;

  // Frame sequencing; a precede-mode frame spends one bit in sync first
  always_comb begin
    next_state = state;
    case (state)
      SFM_IDLE: begin
        if (start_ok) begin
          next_state = (framed_mode_enable && !sync_pulse_edge_select) ?
            SFM_SYNC : SFM_SHIFT;
        end
      end
      SFM_SYNC: begin
        if (last_half) next_state = SFM_SHIFT;
      end
      SFM_SHIFT: begin
        if (last_half && (bit_cnt == last_bit)) next_state = SFM_DONE;
      end
      SFM_DONE: begin
        next_state = SFM_IDLE;
      end
      default: begin
        next_state = SFM_IDLE;
      end
    endcase
    if (!enable) next_state = SFM_IDLE;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= SFM_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Half-bit phase and bit counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half <= 1'b0;
      bit_cnt <= 5'h00;
    end else if (ce) begin
      if (state == SFM_IDLE) begin
        half <= 1'b0;
        bit_cnt <= 5'h00;
      end else if (tick) begin
        half <= !half;
        if (state == SFM_SHIFT && half) bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Shifters: byte words are left aligned so the MSB leads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
    end else if (ce) begin
      if (tx_pop.ready) begin
        tx_shift <= mode16 ? tx_pop.data : {tx_pop.data[7:0], 8'h00};
        rx_shift <= 16'h0000;
      end else if (state == SFM_SHIFT && tick) begin
        if (!half) rx_shift <= {rx_shift[14:0], sdi_in};
        else tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // Receive holding register; a new word beats a same-cycle read
  wire word_done = (state == SFM_DONE);
  wire rx_clear = ce && rd_commit && hit_rx;
  wire ovf_clear = ce && wr_commit && hit_status && wb_dat_i[SFM_S_RXOVF];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 16'h0000;
      rx_full <= 1'b0;
      rx_overflow <= 1'b0;
    end else if (ce) begin
      if (word_done) begin
        rx_data <= rx_shift;
        rx_full <= 1'b1;
      end else if (rx_clear) begin
        rx_full <= 1'b0;
      end
      if (word_done && rx_full && !rx_clear) rx_overflow <= 1'b1;
      else if (ovf_clear) rx_overflow <= 1'b0;
    end
  end

  // Bit clock: active half chosen so data moves on the chosen edge
  wire sck_active = (state == SFM_SHIFT) && (half == cke_eff);
  assign sck_out = ckp ^ sck_active;
  assign sdo_out = tx_shift[15];

  // Sync pulse lasts one bit: before the first bit or with it
  wire sync_active = sync_is_output && ((state == SFM_SYNC) ||
    ((state == SFM_SHIFT) && sync_pulse_edge_select && (bit_cnt == 5'h00)));
  // Pin is driven only as a sync output; else it is left to the port
  assign slave_select_pin_oe_n = !sync_is_output;
  assign slave_select_pin_out = sync_pulse_polarity ? sync_active : !sync_active;
endmodule // sfm_spi_top
